// ==== design/mfpg_pkg.sv ====
package mfpg_pkg;
    // register index width; byte address = index * 4
    localparam int IDX_W    = 12;
    localparam int ADDR_LSB = 2;
    localparam int P5_W     = 5;
    localparam int P8_W     = 8;

    // register indices
    localparam logic [IDX_W-1:0] IDX_P5_LATCH = 12'h005;
    localparam logic [IDX_W-1:0] IDX_P6_DATA  = 12'h006;
    localparam logic [IDX_W-1:0] IDX_P7_DATA  = 12'h007;
    localparam logic [IDX_W-1:0] IDX_P5_PIN   = 12'h00F;
    localparam logic [IDX_W-1:0] IDX_P6_DIR   = 12'hF9B;
    localparam logic [IDX_W-1:0] IDX_P6_SEL   = 12'hF9C;
    localparam logic [IDX_W-1:0] IDX_P7_DIR   = 12'hF9D;
    localparam logic [IDX_W-1:0] IDX_P7_SEL   = 12'hF9E;
    localparam logic [IDX_W-1:0] IDX_P6_BITOP = 12'hFA0;
    localparam logic [IDX_W-1:0] IDX_P7_BITOP = 12'hFA1;
    localparam logic [IDX_W-1:0] IDX_WAKE_EN  = 12'hFA2;

    // reset values
    localparam logic [P5_W-1:0] P5_LATCH_RST = 5'h1F;
    localparam logic [P8_W-1:0] LATCH_RST    = 8'h00;
    localparam logic [P8_W-1:0] DIR_RST      = 8'h00;
    localparam logic [P8_W-1:0] SEL_RST      = 8'hFF;
    localparam logic [P8_W-1:0] WAKE_RST     = 8'h00;

    // bit-manipulation write word: [2:0] bit number, [3] new value
    localparam int BITOP_IDX_LSB = 0;
    localparam int BITOP_IDX_W   = 3;
    localparam int BITOP_VAL_POS = 3;

    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // configuration of one 8-bit port
    typedef struct packed {
        logic [P8_W-1:0] latch;
        logic [P8_W-1:0] dir;
        logic [P8_W-1:0] sel;
    } mfpg_port_cfg_t;

    // captured bus address phase
    typedef struct packed {
        logic             valid;
        logic             write;
        logic [IDX_W-1:0] idx;
    } mfpg_addr_ph_t;

    // per bit: latch when output, pin when digital input, zero when analog
    function automatic logic [P8_W-1:0] mfpg_read_view(input mfpg_port_cfg_t cfg,
                                                       input logic [P8_W-1:0] pins);
        mfpg_read_view = (cfg.dir & cfg.latch) | (~cfg.dir & cfg.sel & pins);
    endfunction : mfpg_read_view
endpackage : mfpg_pkg

// ==== design/mfpg_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous pin levels
module mfpg_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;   // first stage, read only by second stage
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;   // second stage
    logic [W-1:0] sync_next;

    // next values: plain shift
    always_comb
    begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // registers, synchronous reset to zero
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule : mfpg_sync

// ==== design/mfpg_port8.sv ====
`timescale 1ns/1ps
// one 8-bit port: latch, direction and input select, with bit-manipulation write
module mfpg_port8
    import mfpg_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    wr_latch,
    input  wire logic                    wr_dir,
    input  wire logic                    wr_sel,
    input  wire logic                    wr_bit,
    input  wire logic [P8_W-1:0]         wdata,
    input  wire logic [P8_W-1:0]         pin_sync,
    output mfpg_pkg::mfpg_port_cfg_t     cfg,
    output mfpg_pkg::mfpg_port_cfg_t     cfg_next_out,
    output logic      [P8_W-1:0]         view_next,
    output logic      [P8_W-1:0]         analog_en
);
    import mfpg_pkg::*;

    mfpg_port_cfg_t  cfg_reg;        // live configuration
    mfpg_port_cfg_t  cfg_next;
    logic [P8_W-1:0] analog_reg;     // pins handed to the converter
    logic [P8_W-1:0] analog_next;
    logic [P8_W-1:0] bit_view;       // read value used by bit-manipulation

    // next configuration from bus writes
    always_comb
    begin
        cfg_next = cfg_reg;
        bit_view = mfpg_read_view(cfg_reg, pin_sync);
        if (wr_latch)
            cfg_next.latch = wdata;
        if (wr_dir)
            cfg_next.dir = wdata;
        if (wr_sel)
            cfg_next.sel = wdata;
        if (wr_bit)
        begin
            // digital input bits pick up the pin level and analog bits zero, as a real read-modify-write would
            bit_view[wdata[BITOP_IDX_LSB +: BITOP_IDX_W]] = wdata[BITOP_VAL_POS];
            cfg_next.latch = bit_view;
        end
        analog_next = ~cfg_next.dir & ~cfg_next.sel;
        view_next   = mfpg_read_view(cfg_next, pin_sync);
    end

    // registers; writes land on the edge that ends the data phase
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cfg_reg.latch <= LATCH_RST;
            cfg_reg.dir   <= DIR_RST;
            cfg_reg.sel   <= SEL_RST;
            analog_reg    <= '0;
        end
        else
        begin
            cfg_reg    <= cfg_next;
            analog_reg <= analog_next;
        end
    end

    assign cfg          = cfg_reg;
    assign cfg_next_out = cfg_next;
    assign analog_en    = analog_reg;
endmodule : mfpg_port8

// ==== design/mfpg_top.sv ====
`timescale 1ns/1ps
module mfpg_top
    import mfpg_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic      [31:0]       hrdata,
    output logic                   hresp,
    // port five, sink-only pins shared with the i2c controller
    input  wire logic [P5_W-1:0]   p5_pin_in,
    output logic      [P5_W-1:0]   p5_pin_out,
    output logic      [P5_W-1:0]   p5_pin_oe,
    input  wire logic [P5_W-1:0]   i2c_pull_low,
    // port six
    input  wire logic [P8_W-1:0]   p6_pin_in,
    output logic      [P8_W-1:0]   p6_pin_out,
    output logic      [P8_W-1:0]   p6_pin_oe,
    output logic      [P8_W-1:0]   p6_analog_en,
    output logic      [P8_W-1:0]   keyon_wake_req,
    // port seven
    input  wire logic [P8_W-1:0]   p7_pin_in,
    output logic      [P8_W-1:0]   p7_pin_out,
    output logic      [P8_W-1:0]   p7_pin_oe,
    output logic      [P8_W-1:0]   p7_analog_en
);
    import mfpg_pkg::*;

    localparam int PIN_W = P5_W + 2 * P8_W;   // all pins through one synchroniser

    // bus state
    mfpg_addr_ph_t   aph_reg;         // address phase held for the data phase
    mfpg_addr_ph_t   aph_next;
    logic [31:0]     hrdata_reg;      // read data, valid during the data phase
    logic [31:0]     hrdata_next;
    logic            hreadyout_reg;   // slave never stretches a transfer
    logic            hresp_reg;       // slave never signals an error

    // port five state
    logic [P5_W-1:0] p5_latch_reg;    // port five output latch
    logic [P5_W-1:0] p5_latch_next;
    logic [P5_W-1:0] p5_out_reg;      // level placed on port five pins
    logic [P5_W-1:0] p5_out_next;
    logic [P5_W-1:0] p5_oe_reg;       // low pull enable of port five pins
    logic [P5_W-1:0] p5_oe_next;

    // wakeup state
    logic [P8_W-1:0] wake_en_reg;     // keyon_wake_enable, per port six pin
    logic [P8_W-1:0] wake_en_next;
    logic [P8_W-1:0] wake_req_reg;    // level request towards the wakeup logic
    logic [P8_W-1:0] wake_req_next;

    // resynchronised pin levels, split per port
    logic [PIN_W-1:0] pins_sync;
    logic [P5_W-1:0]  p5_sync;
    logic [P8_W-1:0]  p6_sync;
    logic [P8_W-1:0]  p7_sync;

    // bus decode
    logic            take;            // an address phase is accepted
    logic [P8_W-1:0] wbyte;           // low byte of the write data
    logic            wr_p5_latch;     // port five latch write
    logic            wr_wake_en;      // wakeup enable write
    logic            wr_p6_latch;     // port six latch write
    logic            wr_p6_dir;
    logic            wr_p6_sel;
    logic            wr_p6_bit;       // port six single-bit write
    logic            wr_p7_latch;
    logic            wr_p7_dir;
    logic            wr_p7_sel;
    logic            wr_p7_bit;

    // configuration and read views handed up by the port modules
    mfpg_port_cfg_t  p6_cfg;          // live port six configuration
    mfpg_port_cfg_t  p6_cfg_next;     // its value after this cycle's writes
    mfpg_port_cfg_t  p7_cfg;
    mfpg_port_cfg_t  p7_cfg_next;
    logic [P8_W-1:0] p6_view_next;    // read view after this cycle's writes
    logic [P8_W-1:0] p7_view_next;

    // every pin level is resynchronised before anything looks at it; the price
    // is two cycles of latency, so a pin level must stand that long to be read
    // back, and a shorter glitch may be missed altogether
    mfpg_sync #(
        .W (PIN_W)
    ) u_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in ({p7_pin_in, p6_pin_in, p5_pin_in}),
        .sync_out (pins_sync)
    );

    assign p5_sync = pins_sync[P5_W-1:0];
    assign p6_sync = pins_sync[P5_W +: P8_W];
    assign p7_sync = pins_sync[P5_W+P8_W +: P8_W];

    // one decoder for every write target: the data phase of a write to this index
    function automatic logic wr_hit(input mfpg_addr_ph_t     aph,
                                    input logic [IDX_W-1:0] idx);
        wr_hit = aph.valid && aph.write && (aph.idx == idx);
    endfunction : wr_hit

    // an address phase is taken only when the bus is ready and the slave selected
    assign take  = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wbyte = hwdata[P8_W-1:0];   // registers are at most byte wide, upper bits ignored

    // port six write strobes
    assign wr_p6_latch = wr_hit(aph_reg, IDX_P6_DATA);
    assign wr_p6_dir   = wr_hit(aph_reg, IDX_P6_DIR);
    assign wr_p6_sel   = wr_hit(aph_reg, IDX_P6_SEL);
    assign wr_p6_bit   = wr_hit(aph_reg, IDX_P6_BITOP);

    // port seven write strobes
    assign wr_p7_latch = wr_hit(aph_reg, IDX_P7_DATA);
    assign wr_p7_dir   = wr_hit(aph_reg, IDX_P7_DIR);
    assign wr_p7_sel   = wr_hit(aph_reg, IDX_P7_SEL);
    assign wr_p7_bit   = wr_hit(aph_reg, IDX_P7_BITOP);

    // local write strobes
    assign wr_p5_latch = wr_hit(aph_reg, IDX_P5_LATCH);
    assign wr_wake_en  = wr_hit(aph_reg, IDX_WAKE_EN);

    // port six: digital, analog or output per bit
    mfpg_port8 u_port6 (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .wr_latch     (wr_p6_latch),
        .wr_dir       (wr_p6_dir),
        .wr_sel       (wr_p6_sel),
        .wr_bit       (wr_p6_bit),
        .wdata        (wbyte),
        .pin_sync     (p6_sync),
        .cfg          (p6_cfg),
        .cfg_next_out (p6_cfg_next),
        .view_next    (p6_view_next),
        .analog_en    (p6_analog_en)
    );

    // port seven: same structure, no wakeup
    mfpg_port8 u_port7 (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .wr_latch     (wr_p7_latch),
        .wr_dir       (wr_p7_dir),
        .wr_sel       (wr_p7_sel),
        .wr_bit       (wr_p7_bit),
        .wdata        (wbyte),
        .pin_sync     (p7_sync),
        .cfg          (p7_cfg),
        .cfg_next_out (p7_cfg_next),
        .view_next    (p7_view_next),
        .analog_en    (p7_analog_en)
    );

    // port six and seven pins come straight from the config flops
    assign p6_pin_out = p6_cfg.latch;
    assign p6_pin_oe  = p6_cfg.dir;
    assign p7_pin_out = p7_cfg.latch;
    assign p7_pin_oe  = p7_cfg.dir;

    // bus group: capture the address phase for the data phase that follows
    always_comb
    begin
        aph_next.valid = take;
        aph_next.write = hwrite;
        aph_next.idx   = haddr[ADDR_LSB +: IDX_W];   // upper address bits alias
    end

    // read data, taken from next-state values so a write just before a read
    // is seen without a wait state; bit-operation and unmapped indices fall
    // through to the default and read as zero
    always_comb
    begin
        hrdata_next = '0;
        if (take && !hwrite)
        begin
            case (haddr[ADDR_LSB +: IDX_W])
                IDX_P5_LATCH: hrdata_next[P5_W-1:0] = p5_latch_next;
                IDX_P5_PIN:   hrdata_next[P5_W-1:0] = p5_sync;
                IDX_P6_DATA:  hrdata_next[P8_W-1:0] = p6_view_next;
                IDX_P6_DIR:   hrdata_next[P8_W-1:0] = p6_cfg_next.dir;
                IDX_P6_SEL:   hrdata_next[P8_W-1:0] = p6_cfg_next.sel;
                IDX_P7_DATA:  hrdata_next[P8_W-1:0] = p7_view_next;
                IDX_P7_DIR:   hrdata_next[P8_W-1:0] = p7_cfg_next.dir;
                IDX_P7_SEL:   hrdata_next[P8_W-1:0] = p7_cfg_next.sel;
                IDX_WAKE_EN:  hrdata_next[P8_W-1:0] = wake_en_next;
                default:      hrdata_next = '0;   // unmapped reads as zero
            endcase
        end
    end

    // bus group registers; ready and response never change, but they stay flops
    // so that every output leaves the block from a register
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            aph_reg       <= '0;           // no data phase pending
            hrdata_reg    <= '0;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= HRESP_OKAY;
        end
        else
        begin
            aph_reg       <= aph_next;
            hrdata_reg    <= hrdata_next;  // stands for the data phase only
            hreadyout_reg <= 1'b1;         // zero wait states
            hresp_reg     <= HRESP_OKAY;
        end
    end

    // port five group: latch write and pin sink control
    always_comb
    begin
        p5_latch_next = p5_latch_reg;
        if (wr_p5_latch)
            p5_latch_next = hwdata[P5_W-1:0];
        // the pin sinks when its latch is zero or the i2c side pulls low; a latch
        // left at one releases the line, which input and i2c use depend on
        p5_oe_next  = ~p5_latch_next | i2c_pull_low;
        p5_out_next = '0;                              // sink only, never drives high
    end

    // port five registers
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            p5_latch_reg <= P5_LATCH_RST;
            p5_out_reg   <= '0;
            p5_oe_reg    <= '0;             // latch all ones: nothing sinks
        end
        else
        begin
            p5_latch_reg <= p5_latch_next;
            p5_out_reg   <= p5_out_next;
            p5_oe_reg    <= p5_oe_next;
        end
    end

    // wakeup group: enable register and the request level; the stop logic
    // that consumes the request lives outside this block
    always_comb
    begin
        wake_en_next = wake_en_reg;
        if (wr_wake_en)
            wake_en_next = wbyte;
        // wakeup only from pins that are inputs; software orders the setup.
        // the request is a level: it stays up while an enabled pin stays high
        wake_req_next = wake_en_next & ~p6_cfg_next.dir & p6_sync;
    end

    // wakeup registers
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wake_en_reg  <= WAKE_RST;
            wake_req_reg <= '0;
        end
        else
        begin
            wake_en_reg  <= wake_en_next;
            wake_req_reg <= wake_req_next;
        end
    end

    // outputs, each straight from a flop
    assign hreadyout      = hreadyout_reg;
    assign hrdata         = hrdata_reg;
    assign hresp          = hresp_reg;
    assign p5_pin_out     = p5_out_reg;
    assign p5_pin_oe      = p5_oe_reg;
    assign keyon_wake_req = wake_req_reg;
endmodule : mfpg_top

// ==== test/mfpg_top_sva.sv ====
`timescale 1ns/1ps
// checker on the top ports: bus answer, write effects, direction read, pin sides
module mfpg_top_sva
    import mfpg_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic [4:0]  p5_pin_out,
    input wire logic [4:0]  p5_pin_oe,
    input wire logic [4:0]  i2c_pull_low,
    input wire logic [7:0]  p6_pin_out,
    input wire logic [7:0]  p6_pin_oe,
    input wire logic [7:0]  p6_analog_en,
    input wire logic [7:0]  p7_pin_out,
    input wire logic [7:0]  p7_pin_oe,
    input wire logic [7:0]  p7_analog_en
);
    mfpg_addr_ph_t aq_reg;  // address phase seen last edge, so now in data phase
    mfpg_addr_ph_t aq_next; // its next value
    // capture accepted requests only; idle cycles clear it
    always_comb
    begin
        aq_next = '0;
        if (hsel && hready && htrans == HTRANS_NONSEQ)
            aq_next = '{1'b1, hwrite, haddr[13:2]};
    end
    // plain register, cleared in reset
    always_ff @(posedge clk_sys)
    begin
        aq_reg <= reset_n ? aq_next : '0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // data phase of a write to the given register
    sequence s_wr(logic [11:0] i);
        aq_reg.valid && aq_reg.write && aq_reg.idx == i;
    endsequence
    // data phase of any read
    sequence s_rd;
        aq_reg.valid && !aq_reg.write;
    endsequence
    property p_bus_ok;
        hreadyout && hresp == HRESP_OKAY;
    endproperty
    property p_p6_dir_wr;
        s_wr(IDX_P6_DIR) |=> p6_pin_oe == $past(hwdata[7:0]);
    endproperty
    property p_p6_latch_wr;
        s_wr(IDX_P6_DATA) |=> p6_pin_out == $past(hwdata[7:0]);
    endproperty
    property p_p7_dir_wr;
        s_wr(IDX_P7_DIR) |=> p7_pin_oe == $past(hwdata[7:0]);
    endproperty
    property p_p7_latch_wr;
        s_wr(IDX_P7_DATA) |=> p7_pin_out == $past(hwdata[7:0]);
    endproperty
    property p_dir_rd;
        s_rd and aq_reg.idx == IDX_P6_DIR |-> hrdata == {24'h0, p6_pin_oe};
    endproperty
    property p_rd_idle;
        !(aq_reg.valid && !aq_reg.write) |-> hrdata == 32'h0;
    endproperty
    property p_analog_in;
        (p6_analog_en & p6_pin_oe) == 8'h00 && (p7_analog_en & p7_pin_oe) == 8'h00;
    endproperty
    property p_p5_sink;
        p5_pin_out == 5'h00;
    endproperty
    property p_p5_i2c;
        $past(reset_n) |-> (p5_pin_oe & $past(i2c_pull_low)) == $past(i2c_pull_low);
    endproperty
    property p_rst_vals;
        $rose(reset_n) |-> (p6_pin_oe | p7_pin_oe | p6_pin_out | p7_pin_out) == 8'h00;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
    a_p6_dir_wr: assert property (p_p6_dir_wr) else $error("port six direction write lost");
    a_p6_latch_wr: assert property (p_p6_latch_wr) else $error("port six latch write lost");
    a_p7_dir_wr: assert property (p_p7_dir_wr) else $error("port seven direction write lost");
    a_p7_latch_wr: assert property (p_p7_latch_wr) else $error("port seven latch write lost");
    a_dir_rd: assert property (p_dir_rd) else $error("direction read differs from enables");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
    a_analog_in: assert property (p_analog_in) else $error("analog pin driven");
    a_p5_sink: assert property (p_p5_sink) else $error("port five drives high");
    a_p5_i2c: assert property (p_p5_i2c) else $error("i2c pull ignored");
    a_rst_vals: assert property (p_rst_vals) else $error("port reset values wrong");
endmodule : mfpg_top_sva

bind mfpg_top mfpg_top_sva chk (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .p5_pin_out(p5_pin_out), .p5_pin_oe(p5_pin_oe),
    .i2c_pull_low(i2c_pull_low), .p6_pin_out(p6_pin_out), .p6_pin_oe(p6_pin_oe),
    .p6_analog_en(p6_analog_en), .p7_pin_out(p7_pin_out), .p7_pin_oe(p7_pin_oe),
    .p7_analog_en(p7_analog_en));

// ==== test/mfpg_pins.sv ====
`timescale 1ns/1ps
// pad model: resolves each pin from the block's enables and the outside drivers
module mfpg_pins (
    input wire logic [4:0] p5_oe,
    input wire logic [4:0] ext5,
    input wire logic [7:0] p6_out,
    input wire logic [7:0] p6_oe,
    input wire logic [7:0] ext6,
    input wire logic [7:0] p7_out,
    input wire logic [7:0] p7_oe,
    input wire logic [7:0] ext7,
    output logic     [4:0] p5_pad,
    output logic     [7:0] p6_pad,
    output logic     [7:0] p7_pad
);
    // port five lines have pull-ups; whoever pulls low wins
    assign p5_pad = ~p5_oe & ext5;
    // a driven pin shows the latch, otherwise the outside level
    assign p6_pad = (p6_oe & p6_out) | (~p6_oe & ext6);
    assign p7_pad = (p7_oe & p7_out) | (~p7_oe & ext7);
endmodule : mfpg_pins

// ==== test/tb_mfpg_top.sv ====
`timescale 1ns/1ps
// self-checking bench: bus tasks, pad model and one task per scenario
module tb_mfpg_top;
    import mfpg_pkg::*;
    logic        clk_sys      = 1'b0;  // 25 MHz
    logic        reset_n      = 1'b0;  // synchronous, active low
    logic        hsel         = 1'b0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [2:0]  hsize        = 3'h2;  // word transfers only
    logic [31:0] hwdata       = 32'h0;
    logic        hreadyout;            // also the bus hready
    logic [31:0] hrdata;
    logic        hresp;
    logic [4:0]  i2c_pull_low = 5'h00;
    logic [4:0]  ext5         = 5'h1F; // outside pulls on port five, high = released
    logic [7:0]  ext6         = 8'hA5;
    logic [7:0]  ext7         = 8'h5A;
    logic [4:0]  p5_in, p5_out, p5_oe;
    logic [7:0]  p6_in, p6_out, p6_oe, p6_an, wake, p7_in, p7_out, p7_oe, p7_an;
    logic [31:0] rd;                   // last read data
    int          n_mismatch   = 0;
    int          cmp_count    = 0;
    int          cyc          = 0;

    always #20 clk_sys = ~clk_sys;

    mfpg_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .p5_pin_in(p5_in), .p5_pin_out(p5_out), .p5_pin_oe(p5_oe),
        .i2c_pull_low(i2c_pull_low), .p6_pin_in(p6_in), .p6_pin_out(p6_out), .p6_pin_oe(p6_oe),
        .p6_analog_en(p6_an), .keyon_wake_req(wake), .p7_pin_in(p7_in), .p7_pin_out(p7_out),
        .p7_pin_oe(p7_oe), .p7_analog_en(p7_an));
    mfpg_pins pads (.p5_oe(p5_oe), .ext5(ext5), .p6_out(p6_out), .p6_oe(p6_oe), .ext6(ext6),
        .p7_out(p7_out), .p7_oe(p7_oe), .ext7(ext7), .p5_pad(p5_in), .p6_pad(p6_in), .p7_pad(p7_in));

    // one single transfer; never assumes a wait count, the watchdog cuts a hang
    task automatic xfer(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {18'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // masked read so undefined upper bits of port five stay unchecked
    task automatic rdchk(input logic [11:0] idx, input logic [31:0] mask, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h0);
        chk(rd & mask, exp);
    endtask : rdchk
    task automatic t_reset;
        rdchk(IDX_P5_LATCH, 32'h1F, 32'h1F);
        rdchk(IDX_P6_DIR, '1, 32'h00);
        rdchk(IDX_P6_SEL, '1, 32'hFF);
        rdchk(IDX_P6_DATA, '1, 32'hA5);
        rdchk(IDX_P7_DIR, '1, 32'h00);
        rdchk(IDX_P7_SEL, '1, 32'hFF);
        rdchk(IDX_P7_DATA, '1, 32'h5A);
        $display("test reset done");
    endtask : t_reset
    task automatic t_p5;
        i2c_pull_low <= 5'h01;
        ext5         <= 5'h1E;
        xfer(IDX_P5_LATCH, 1'b1, 32'h0B);
        repeat (3) @(posedge clk_sys);
        chk(p5_oe, 32'h15);
        rdchk(IDX_P5_LATCH, 32'h1F, 32'h0B);
        rdchk(IDX_P5_PIN, 32'h1F, 32'h0A);
        i2c_pull_low <= 5'h00;
        xfer(IDX_P5_LATCH, 1'b1, 32'h1F);
        $display("test port five done");
    endtask : t_p5
    // n selects port six (0) or seven (1); their indices sit at fixed strides
    task automatic t_port(input int n);
        logic [11:0] dr;
        logic [11:0] sl;
        logic [11:0] dt;
        dr = IDX_P6_DIR + 12'(2 * n);
        sl = IDX_P6_SEL + 12'(2 * n);
        dt = IDX_P6_DATA + 12'(n);
        // no conversion runs here; pins settle before any pin turns analog and then stay quiet
        if (n == 1) ext7 <= 8'h3C;
        else ext6 <= 8'h3C;
        xfer(dr, 1'b1, 32'hF0);
        xfer(sl, 1'b1, 32'hCC);
        xfer(dt, 1'b1, 32'hA5);
        repeat (3) @(posedge clk_sys);
        chk(n == 1 ? p7_oe : p6_oe, 32'hF0);
        chk(n == 1 ? p7_out : p6_out, 32'hA5);
        chk(n == 1 ? p7_an : p6_an, 32'h03);
        rdchk(dt, '1, 32'hAC);
        xfer(IDX_P6_BITOP + 12'(n), 1'b1, 32'h09);
        @(posedge clk_sys);
        chk(n == 1 ? p7_out : p6_out, 32'hAE);
        xfer(sl, 1'b1, 32'hFF);
        xfer(dr, 1'b1, 32'hFF);
        rdchk(dt, '1, 32'hAE);
        xfer(dr, 1'b1, 32'h00);
        $display("test port %0d done", n + 6);
    endtask : t_port
    task automatic t_wake;
        ext6 <= 8'hC0;
        xfer(IDX_P6_DIR, 1'b1, 32'h00);
        xfer(IDX_WAKE_EN, 1'b1, 32'h81);
        repeat (3) @(posedge clk_sys);
        chk(wake, 32'h80);
        rdchk(12'h100, '1, 32'h00);
        $display("test wake done");
    endtask : t_wake
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    // watchdog: the whole run needs well under 2000 cycles
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_p5();
        t_port(0);
        t_port(1);
        t_wake();
        conclude();
    end
endmodule : tb_mfpg_top
